// ### hdl/afe_trim_pkg.sv
// Constants, types and decode helpers for the front-end trim register bank.
// Assumes a byte-addressed Avalon-MM slave with 32-bit data words.
package afe_trim_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int AMP_N = 2;
    localparam logic [ADDR_W-1:0] OFS_CFG = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_DAC = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_AMP0 = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_AMP1 = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_CMP = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_ENA = 5'h14;
    localparam int CFG_W = 6;
    localparam int HYS_LSB = 4;
    localparam int BIAS_LSB = 2;
    localparam int SPD1_BIT = 1;
    localparam int SPD0_BIT = 0;
    localparam int CAL_MODE_BIT = 7;
    localparam int CAL_REF_BIT = 6;
    localparam int AMP_TRIM_W = 6;
    localparam int CMP_OUT_BIT = 7;
    localparam int CMP_MODE_BIT = 6;
    localparam int CMP_REF_BIT = 5;
    localparam int CMP_TRIM_W = 5;
    localparam int CMP_CTL_W = 7;
    localparam logic [CFG_W-1:0] CFG_RST = 6'h00;
    localparam logic [7:0] DAC_RST = 8'h00;
    localparam logic [7:0] AMP_CAL_RST = 8'h20;
    localparam logic [CMP_CTL_W-1:0] CMP_CAL_RST = 7'h10;
    localparam logic RESP_OKAY_B = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;

    function automatic logic [ADDR_W-1:0] amp_ofs(input int i);
        amp_ofs = (i == 0) ? OFS_AMP0 : OFS_AMP1;
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == OFS_CFG) || (a == OFS_DAC) || (a == OFS_AMP0)
            || (a == OFS_AMP1) || (a == OFS_CMP) || (a == OFS_ENA);
    endfunction
endpackage

// ### hdl/cmp_link_if.sv
// Carrier between the register bank and the comparator result stage.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface cmp_link_if;
    logic enable;
    logic result;
    modport bank (output enable, input result);
    modport stage (input enable, output result);
endinterface
`default_nettype wire

// ### hdl/cmp_result_sync.sv
// Comparator result stage: synchronises the analog comparator output.
// Assumes the raw comparator level is asynchronous to mclk.
`timescale 1ns/1ns
`default_nettype none
module cmp_result_sync
    import afe_trim_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Analog side
    input wire logic cmp_raw,
    // Bank side
    cmp_link_if.stage link
);
    logic s1_q, s1_d;
    logic s2_q, s2_d;
    logic res_q, res_d;

    always_comb begin
        s1_d = cmp_raw;
        s2_d = s1_q;
        // Forced low while disabled, so a floating comparator never leaks through
        res_d = link.enable ? s2_q : 1'b0;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            res_q <= 1'b0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            res_q <= res_d;
        end
    end

    assign link.result = res_q;
endmodule // cmp_result_sync
`default_nettype wire

// ### hdl/proximity_afe_trim_regs.sv
// Trim and configuration register bank for the proximity front end.
// Assumes an Avalon-MM master on mclk and analog circuits on the outputs.
`timescale 1ns/1ns
`default_nettype none
module proximity_afe_trim_regs
    import afe_trim_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [DATA_W-1:0] writedata,
    input wire logic [BE_W-1:0] byteenable,
    output logic [DATA_W-1:0] readdata,
    output logic [1:0] response,
    output logic waitrequest,
    // Comparator
    input wire logic cmp_raw,
    output logic cmp_result,
    output logic cmp_dac_enable,
    output logic [1:0] cmp_hysteresis_sel,
    output logic [1:0] cmp_bias_sel,
    output logic cmp_cal_mode,
    output logic cmp_cal_ref_sel,
    output logic [CMP_TRIM_W-1:0] cmp_trim_code,
    // Reference DAC
    output logic [7:0] dac_code,
    // Amplifiers
    output logic amp_zero_speed_sel,
    output logic amp_one_speed_sel,
    output logic amp_zero_cal_mode,
    output logic amp_zero_cal_ref_sel,
    output logic [AMP_TRIM_W-1:0] amp_zero_trim_code,
    output logic amp_one_cal_mode,
    output logic amp_one_cal_ref_sel,
    output logic [AMP_TRIM_W-1:0] amp_one_trim_code
);
    bus_state_t state_q, state_d;
    logic wait_q, wait_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [1:0] resp_q, resp_d;
    logic [CFG_W-1:0] cfg_q, cfg_d;
    logic [7:0] dac_q, dac_d;
    logic [7:0] amp_q [AMP_N];
    logic [7:0] amp_d [AMP_N];
    logic [CMP_CTL_W-1:0] cmp_q, cmp_d;
    logic ena_q, ena_d;
    logic [7:0] rd_byte;
    logic wr_go;

    cmp_link_if u_link ();

    cmp_result_sync u_sync (
        .mclk(mclk),
        .rstn(rstn),
        .cmp_raw(cmp_raw),
        .link(u_link.stage)
    );

    assign u_link.enable = ena_q;

    // One wait cycle: the read word is captured on the taking edge,
    // so the mux never sits on the answer path of the bus.
    always_comb begin
        state_d = state_q;
        wait_d = 1'b1;
        rdata_d = rdata_q;
        resp_d = resp_q;
        cfg_d = cfg_q;
        dac_d = dac_q;
        amp_d = amp_q;
        cmp_d = cmp_q;
        ena_d = ena_q;
        wr_go = 1'b0;
        rd_byte = 8'h00;
        case (address)
            OFS_CFG: rd_byte = {2'b00, cfg_q};
            OFS_DAC: rd_byte = dac_q;
            OFS_AMP0: rd_byte = amp_q[0];
            OFS_AMP1: rd_byte = amp_q[1];
            OFS_CMP: rd_byte = {u_link.result, cmp_q};
            OFS_ENA: rd_byte = {7'h00, ena_q};
            default: rd_byte = 8'h00;
        endcase
        case (state_q)
            BUS_IDLE: begin
                if (read || write) begin
                    state_d = BUS_ACK;
                    wait_d = 1'b0;
                    rdata_d = read ? {24'h000000, rd_byte} : {DATA_W{1'b0}};
                    resp_d = is_mapped(address) ? RESP_OKAY : RESP_DECERR;
                end
            end
            BUS_ACK: begin
                state_d = BUS_IDLE;
                wr_go = write && byteenable[0];
                if (wr_go) begin
                    // Bits 7..6 dropped: they have no storage
                    if (address == OFS_CFG) begin
                        cfg_d = writedata[CFG_W-1:0];
                    end
                    if (address == OFS_DAC) begin
                        dac_d = writedata[7:0];
                    end
                    for (int i = 0; i < AMP_N; i++) begin
                        if (address == amp_ofs(i)) begin
                            amp_d[i] = writedata[7:0];
                        end
                    end
                    // Result bit is read-only; only 6..0 are stored
                    if (address == OFS_CMP) begin
                        cmp_d = writedata[CMP_CTL_W-1:0];
                    end
                    if (address == OFS_ENA) begin
                        ena_d = writedata[0];
                    end
                end
            end
            default: begin
                state_d = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_q <= BUS_IDLE;
            wait_q <= 1'b1;
            rdata_q <= {DATA_W{1'b0}};
            resp_q <= RESP_OKAY;
            cfg_q <= CFG_RST;
            dac_q <= DAC_RST;
            amp_q[0] <= AMP_CAL_RST;
            amp_q[1] <= AMP_CAL_RST;
            cmp_q <= CMP_CAL_RST;
            ena_q <= 1'b0;
        end else begin
            state_q <= state_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            resp_q <= resp_d;
            cfg_q <= cfg_d;
            dac_q <= dac_d;
            amp_q <= amp_d;
            cmp_q <= cmp_d;
            ena_q <= ena_d;
        end
    end

    assign readdata = rdata_q;
    assign response = resp_q;
    assign waitrequest = wait_q;
    assign cmp_result = u_link.result;
    assign cmp_dac_enable = ena_q;
    assign cmp_hysteresis_sel = cfg_q[HYS_LSB+1:HYS_LSB];
    assign cmp_bias_sel = cfg_q[BIAS_LSB+1:BIAS_LSB];
    assign amp_one_speed_sel = cfg_q[SPD1_BIT];
    assign amp_zero_speed_sel = cfg_q[SPD0_BIT];
    assign dac_code = dac_q;
    assign amp_zero_cal_mode = amp_q[0][CAL_MODE_BIT];
    assign amp_zero_cal_ref_sel = amp_q[0][CAL_REF_BIT];
    assign amp_zero_trim_code = amp_q[0][AMP_TRIM_W-1:0];
    assign amp_one_cal_mode = amp_q[1][CAL_MODE_BIT];
    assign amp_one_cal_ref_sel = amp_q[1][CAL_REF_BIT];
    assign amp_one_trim_code = amp_q[1][AMP_TRIM_W-1:0];
    assign cmp_cal_mode = cmp_q[CMP_MODE_BIT];
    assign cmp_cal_ref_sel = cmp_q[CMP_REF_BIT];
    assign cmp_trim_code = cmp_q[CMP_TRIM_W-1:0];

    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    logic acc_wr, acc_rd;
    assign acc_wr = write && !waitrequest && byteenable[0];
    assign acc_rd = read && !waitrequest;

    chk_cfg_top_zero: assert property (
        acc_rd && address == OFS_CFG |-> readdata[7:6] == 2'b00
            && readdata[5:0] == cfg_q)
        else $error("config read shows nonzero upper bits");

    chk_hyst_bias_wr: assert property (
        acc_wr && address == OFS_CFG |=> cmp_hysteresis_sel == $past(writedata[5:4])
            && cmp_bias_sel == $past(writedata[3:2]))
        else $error("hysteresis or bias select not updated");

    chk_speed_wr: assert property (
        acc_wr && address == OFS_CFG |=> amp_one_speed_sel == $past(writedata[1])
            && amp_zero_speed_sel == $past(writedata[0]))
        else $error("amplifier speed select not updated");

    chk_dac_wr: assert property (
        acc_wr && address == OFS_DAC |=> dac_code == $past(writedata[7:0]))
        else $error("DAC code not updated");

    chk_amp0_wr: assert property (
        acc_wr && address == OFS_AMP0 |=> {amp_zero_cal_mode, amp_zero_cal_ref_sel,
            amp_zero_trim_code} == $past(writedata[7:0]))
        else $error("amp zero calibration fields not updated");

    chk_amp1_wr: assert property (
        acc_wr && address == OFS_AMP1 |=> {amp_one_cal_mode, amp_one_cal_ref_sel,
            amp_one_trim_code} == $past(writedata[7:0]))
        else $error("amp one calibration fields not updated");

    chk_trim_reset: assert property (
        !$past(rstn) |-> amp_zero_trim_code == 6'h20 && amp_one_trim_code == 6'h20
            && cmp_trim_code == 5'h10)
        else $error("trim codes wrong after reset");

    chk_result_read: assert property (
        acc_rd && address == OFS_CMP |-> readdata[7] == $past(cmp_result))
        else $error("comparator result not returned on read");

    chk_result_forced: assert property (
        !cmp_dac_enable ##1 !cmp_dac_enable |-> !cmp_result ##1 !cmp_result)
        else $error("result not forced low while disabled");

    chk_cmp_wr: assert property (
        acc_wr && address == OFS_CMP |=> cmp_trim_code == $past(writedata[4:0])
            && cmp_cal_mode == $past(writedata[6])
            && ($past(cmp_dac_enable) || !cmp_result))
        else $error("comparator write mishandled");

    chk_wait_one: assert property (
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("wait state length wrong");

    // Fields hold between writes: a stray strobe would retune the analog side
    chk_cfg_hold: assert property (
        !(acc_wr && address == OFS_CFG) |=> $stable(cfg_q))
        else $error("config register changed without a write");

    chk_dac_hold: assert property (
        !(acc_wr && address == OFS_DAC) |=> $stable(dac_code))
        else $error("DAC code changed without a write");

    chk_amp0_hold: assert property (
        !(acc_wr && address == OFS_AMP0) |=> $stable(amp_q[0]))
        else $error("amp zero register changed without a write");

    chk_amp1_hold: assert property (
        !(acc_wr && address == OFS_AMP1) |=> $stable(amp_q[1]))
        else $error("amp one register changed without a write");

    chk_cmp_hold: assert property (
        !(acc_wr && address == OFS_CMP) |=> $stable(cmp_q))
        else $error("comparator register changed without a write");

    chk_ena_wr: assert property (
        acc_wr && address == OFS_ENA |=> cmp_dac_enable == $past(writedata[0]))
        else $error("enable bit not updated");

    chk_ena_hold: assert property (
        !(acc_wr && address == OFS_ENA) |=> $stable(cmp_dac_enable))
        else $error("enable bit changed without a write");

    chk_amp0_ref: assert property (
        acc_wr && address == OFS_AMP0 |=> amp_zero_cal_ref_sel == $past(writedata[6]))
        else $error("amp zero reference select not updated");

    chk_cmp_ref_wr: assert property (
        acc_wr && address == OFS_CMP |=> cmp_cal_ref_sel == $past(writedata[5]))
        else $error("comparator reference select not updated");

    chk_read_upper: assert property (
        acc_rd |-> readdata[DATA_W-1:8] == 24'h000000)
        else $error("read data upper lanes not zero");

    chk_decerr_resp: assert property (
        (read || write) && !waitrequest && !is_mapped(address)
            |-> response == RESP_DECERR && readdata == {DATA_W{1'b0}})
        else $error("unmapped access not answered with decode error");

    chk_okay_resp: assert property (
        (read || write) && !waitrequest && is_mapped(address) |-> response == RESP_OKAY)
        else $error("mapped access not answered okay");

    chk_result_sync: assert property (
        $past(cmp_dac_enable) |-> cmp_result == $past(cmp_raw, 3))
        else $error("comparator result latency wrong");

    chk_result_low: assert property (
        !$past(cmp_dac_enable) |-> !cmp_result)
        else $error("result high one cycle after disable");

    chk_wait_reset: assert property (
        !$past(rstn) |-> waitrequest && readdata == {DATA_W{1'b0}})
        else $error("bus outputs wrong after reset");

    chk_wait_idle: assert property (
        !read && !write && waitrequest |=> waitrequest)
        else $error("waitrequest dropped without a request");

    chk_cfg_reset: assert property (
        !$past(rstn) |-> cfg_q == CFG_RST && dac_code == DAC_RST && !cmp_dac_enable
            && cmp_q == CMP_CAL_RST)
        else $error("register reset values wrong");

    chk_lane_off: assert property (
        write && !waitrequest && !byteenable[0]
            |=> $stable(cfg_q) && $stable(dac_code) && $stable(cmp_q))
        else $error("write with low lane disabled changed a register");

    cov_lane_off: cover property (write && !waitrequest && !byteenable[0]);
    cov_amp_cal: cover property (acc_wr && address == OFS_AMP1 && writedata[7]);
    cov_cmp_read: cover property (acc_rd && address == OFS_CMP && readdata[7]);
    cov_unmapped: cover property (acc_rd && response == RESP_DECERR);
    cov_enable: cover property (acc_wr && address == OFS_ENA && writedata[0]);
endmodule // proximity_afe_trim_regs
`default_nettype wire

// ### test/test_proximity_afe_trim_regs.sv
// Self-checking bench for the front-end trim register bank.
// Assumes the bank answers each Avalon-MM request within 50 cycles.
`timescale 1ns/1ns
`default_nettype none
module test_proximity_afe_trim_regs
    import afe_trim_pkg::*;
;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [ADDR_W-1:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [DATA_W-1:0] writedata = '0;
    logic [BE_W-1:0] byteenable = 4'hF;
    logic [DATA_W-1:0] readdata;
    logic [1:0] response;
    logic waitrequest;
    logic cmp_raw = 1'b0;
    logic cmp_result, cmp_dac_enable, amp_zero_speed_sel, amp_one_speed_sel;
    logic [1:0] cmp_hysteresis_sel, cmp_bias_sel;
    logic cmp_cal_mode, cmp_cal_ref_sel, amp_zero_cal_mode, amp_zero_cal_ref_sel;
    logic amp_one_cal_mode, amp_one_cal_ref_sel;
    logic [CMP_TRIM_W-1:0] cmp_trim_code;
    logic [7:0] dac_code;
    logic [AMP_TRIM_W-1:0] amp_zero_trim_code, amp_one_trim_code;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [7:0] vals [3] = '{8'hFF, 8'h96, 8'h69};
    int err_count = 0;
    int comparisons = 0;
    int avg;

    proximity_afe_trim_regs u_proximity_afe_trim_regs (
        .mclk(mclk), .rstn(rstn), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .response(response), .waitrequest(waitrequest), .cmp_raw(cmp_raw),
        .cmp_result(cmp_result), .cmp_dac_enable(cmp_dac_enable),
        .cmp_hysteresis_sel(cmp_hysteresis_sel), .cmp_bias_sel(cmp_bias_sel),
        .cmp_cal_mode(cmp_cal_mode), .cmp_cal_ref_sel(cmp_cal_ref_sel),
        .cmp_trim_code(cmp_trim_code), .dac_code(dac_code),
        .amp_zero_speed_sel(amp_zero_speed_sel), .amp_one_speed_sel(amp_one_speed_sel),
        .amp_zero_cal_mode(amp_zero_cal_mode), .amp_zero_cal_ref_sel(amp_zero_cal_ref_sel),
        .amp_zero_trim_code(amp_zero_trim_code), .amp_one_cal_mode(amp_one_cal_mode),
        .amp_one_cal_ref_sel(amp_one_cal_ref_sel), .amp_one_trim_code(amp_one_trim_code)
    );

    always #2 mclk = ~mclk;

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Request is held until waitrequest is sampled low; no latency assumed
    task automatic bus_xfer(input logic [4:0] a, input logic wr, input logic [7:0] wd,
                            input logic [3:0] be);
        int n;
        n = 0;
        @(posedge mclk);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= {24'h0, wd};
        byteenable <= be;
        do begin
            @(posedge mclk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) check(32'h0, 32'h1, "bus answer missing");
        rdata = readdata;
        rresp = response;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus_xfer(a, 1'b1, d, 4'h1);
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp, input string what);
        bus_xfer(a, 1'b0, 8'h00, 4'hF);
        check(rdata, {24'h0, exp}, what);
        check(32'(rresp), 32'(RESP_OKAY), "read response");
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        rd_chk(OFS_CFG, 8'h00, "cfg reset");
        rd_chk(OFS_DAC, 8'h00, "dac reset");
        rd_chk(OFS_AMP0, 8'h20, "amp0 reset");
        rd_chk(OFS_AMP1, 8'h20, "amp1 reset");
        rd_chk(OFS_CMP, 8'h10, "cmp reset");
        rd_chk(OFS_ENA, 8'h00, "enable reset");
        $display("test reset_values done");
        foreach (vals[i]) begin
            wr(OFS_CFG, vals[i]);
            rd_chk(OFS_CFG, vals[i] & 8'h3F, "cfg readback");
            @(posedge mclk);
            check(32'({cmp_hysteresis_sel, cmp_bias_sel, amp_one_speed_sel,
                       amp_zero_speed_sel}), 32'(vals[i][5:0]), "cfg fields");
        end
        // Byte lane off: the write must leave the register alone
        bus_xfer(OFS_CFG, 1'b1, 8'h00, 4'h0);
        rd_chk(OFS_CFG, 8'h29, "cfg lane off");
        foreach (vals[i]) begin
            wr(OFS_DAC, ~vals[i]);
            rd_chk(OFS_DAC, ~vals[i], "dac readback");
            @(posedge mclk);
            check(32'(dac_code), {24'h0, ~vals[i]}, "dac code");
        end
        $display("test cfg_dac done");
        for (int i = 0; i < 2; i++) begin
            foreach (vals[k]) begin
                wr(i == 0 ? OFS_AMP0 : OFS_AMP1, vals[k]);
                rd_chk(i == 0 ? OFS_AMP0 : OFS_AMP1, vals[k], "amp readback");
                @(posedge mclk);
                check(i == 0 ? 32'({amp_zero_cal_mode, amp_zero_cal_ref_sel, amp_zero_trim_code})
                      : 32'({amp_one_cal_mode, amp_one_cal_ref_sel, amp_one_trim_code}),
                      32'(vals[k]), "amp fields");
            end
            if (i == 0) rd_chk(OFS_AMP1, 8'h20, "amp1 untouched");
        end
        $display("test amp_regs done");
        wr(OFS_CMP, 8'hFF);
        rd_chk(OFS_CMP, 8'h7F, "cmp result bit write");
        @(posedge mclk);
        check(32'({cmp_cal_mode, cmp_cal_ref_sel, cmp_trim_code}), 32'h7F, "cmp fields");
        // Calibration order: mode first, then reference, then sweep the trim
        wr(OFS_CMP, 8'h40);
        wr(OFS_CMP, 8'h60);
        // Upward from all zeros, then downward from all ones
        for (int t = 0; t < 64; t++) begin
            wr(OFS_CMP, 8'h60 | 8'(t < 32 ? t : 63 - t));
            rd_chk(OFS_CMP, 8'h60 | 8'(t < 32 ? t : 63 - t), "cmp sweep");
        end
        avg = (3 + 28) / 2;
        wr(OFS_CMP, 8'h60 | 8'(avg));
        avg = (5 + 58) / 2;
        wr(OFS_AMP0, 8'hC0 | 8'(avg));
        rd_chk(OFS_AMP0, 8'hDF, "amp average");
        $display("test calibration done");
        cmp_raw <= 1'b1;
        repeat (5) @(posedge mclk);
        check(32'(cmp_result), 32'h0, "result while disabled");
        rd_chk(OFS_CMP, 8'h6F, "result bit disabled");
        wr(OFS_ENA, 8'h01);
        repeat (5) @(posedge mclk);
        check(32'(cmp_dac_enable), 32'h1, "enable out");
        check(32'(cmp_result), 32'h1, "result high");
        rd_chk(OFS_CMP, 8'hEF, "result bit high");
        cmp_raw <= 1'b0;
        repeat (5) @(posedge mclk);
        rd_chk(OFS_CMP, 8'h6F, "result bit low");
        cmp_raw <= 1'b1;
        repeat (5) @(posedge mclk);
        wr(OFS_ENA, 8'h00);
        repeat (2) @(posedge mclk);
        check(32'(cmp_result), 32'h0, "result forced low");
        $display("test comparator done");
        // Unmapped space must answer with a decode error and store nothing
        bus_xfer(5'h18, 1'b0, 8'h00, 4'hF);
        check(rdata, 32'h0, "unmapped data");
        check(32'(rresp), 32'(RESP_DECERR), "unmapped response");
        bus_xfer(5'h18, 1'b1, 8'hFF, 4'hF);
        rd_chk(OFS_CFG, 8'h29, "cfg after unmapped write");
        $display("test unmapped done");
        close_out();
    end

    // Tests need under a thousand cycles; this span leaves wide margin
    initial begin
        #40000;
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        close_out();
    end
endmodule // test_proximity_afe_trim_regs
`default_nettype wire
